// File: common/ccpm_map.svh
// Register offsets, field positions and reset values of the clock output block.
`ifndef CCPM_MAP_SVH
`define CCPM_MAP_SVH

`define CCPM_OFF_CLK_CFG 8'h00
`define CCPM_OFF_PWR_CTRL 8'h04
`define CCPM_OFF_STATUS 8'h08

`define CCPM_CLK_CFG_RESET 8'h29
`define CCPM_SLOW_DIV_LSB 6
`define CCPM_FAST_DIV_LSB 4
`define CCPM_ACT_SEL_LSB 2
`define CCPM_SLP_SEL_LSB 0

`define CCPM_PWR_CTRL_RESET 8'h00
`define CCPM_MODE_LSB 0
`define CCPM_GPD_BIT 4

`define CCPM_ST_STATE_LSB 0
`define CCPM_ST_FAST_BIT 3
`define CCPM_ST_DOUBLER_BIT 4
`define CCPM_ST_PIN_BIT 5
`define CCPM_ST_SRC_LSB 6

`define CCPM_RESP_OKAY 2'h0
`define CCPM_RESP_DECERR 2'h3

`endif

// File: common/ccpm_pkg.sv
// Types shared by the clock output and power mode block.
package ccpm_pkg;

  typedef enum logic [1:0] {
    CCPM_MODE_IDLE,
    CCPM_MODE_TX,
    CCPM_MODE_RX,
    CCPM_MODE_SLEEP
  } ccpm_mode_t;

  typedef enum logic [2:0] {
    CCPM_PS_IDLE,
    CCPM_PS_TX,
    CCPM_PS_RX,
    CCPM_PS_SLEEP,
    CCPM_PS_PDOWN
  } ccpm_pstate_t;

  typedef enum logic [1:0] {
    CCPM_SRC_OFF,
    CCPM_SRC_SLOW,
    CCPM_SRC_FAST
  } ccpm_src_t;

  typedef enum logic [1:0] {
    CCPM_SW_RUN,
    CCPM_SW_DRAIN,
    CCPM_SW_ARM
  } ccpm_sw_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } ccpm_sync_state_t;

  typedef struct packed {
    logic [7:0] clk_cfg;
    ccpm_mode_t mode;
    logic global_power_down;
    ccpm_pstate_t pstate;
    logic fast_en;
    logic doubler;
    logic tx_en;
    logic rx_en;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ccpm_sw_t sw;
    ccpm_src_t cur_src;
    logic pin;
  } ccpm_state_t;

  // Values 0 and 3 both mean off.
  function automatic ccpm_src_t ccpm_decode_src(input logic [1:0] sel);
    ccpm_src_t src;
    case (sel)
      2'h1: src = CCPM_SRC_SLOW;
      2'h2: src = CCPM_SRC_FAST;
      default: src = CCPM_SRC_OFF;
    endcase
    return src;
  endfunction

endpackage

// File: hw/ccpm_sync.sv
// Three-stage synchroniser with agreement filter for an oscillator input.
`timescale 1ns/1ns
module ccpm_sync
  import ccpm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);

  ccpm_sync_state_t state_reg;
  ccpm_sync_state_t state_next;

  // The first stage feeds only the second; the filter compares stages two and three.
  always_comb
  begin
    state_next = state_reg;
    state_next.s1 = async_i;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.rise = 1'b0;
    if (state_reg.s2 == state_reg.s3)
    begin
      state_next.level = state_reg.s3;
      state_next.rise = state_reg.s3 & ~state_reg.level;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign level_o = state_reg.level;
  assign rise_o = state_reg.rise;

endmodule

// File: hw/ccpm_divider.sv
// Power-of-two divider of a sampled reference clock.
`timescale 1ns/1ns
module ccpm_divider
  import ccpm_pkg::*;
#(
  parameter int SEL_W = 2
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic level_i,
  input wire logic rise_i,
  input wire logic [SEL_W-1:0] ratio_i,
  output logic clock_o
);

  localparam int CNT_W = (1 << SEL_W) - 1;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic out;
  } ccpm_div_state_t;

  ccpm_div_state_t state_reg;
  ccpm_div_state_t state_next;
  logic [CNT_W-1:0] half_m1;

  if (SEL_W < 1 || SEL_W > 3)
  begin : g_check
    $error("ccpm_divider: SEL_W must lie between 1 and 3");
  end

  // Ratio k divides by 2**k; the output toggles every 2**(k-1) rising edges.
  always_comb
  begin
    half_m1 = '0;
    if (ratio_i != '0)
      half_m1 = CNT_W'((CNT_W'(1) << (ratio_i - SEL_W'(1))) - CNT_W'(1));
    state_next = state_reg;
    if (!enable_i)
    begin
      state_next.cnt = '0;
      state_next.out = 1'b0;
    end
    else if (ratio_i == '0)
    begin
      state_next.cnt = '0;
      state_next.out = level_i;
    end
    else if (rise_i)
    begin
      if (state_reg.cnt >= half_m1)
      begin
        state_next.cnt = '0;
        state_next.out = ~state_reg.out;
      end
      else
        state_next.cnt = CNT_W'(state_reg.cnt + 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign clock_o = state_reg.out;

endmodule

// File: hw/ccpm_top.sv
// Clock source gating, clock output selection and power mode control with AXI4-Lite registers.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "ccpm_map.svh"

// Summary of operation
// (R1) The slow divider field in bits 7:6 divides the 32.768 kHz clock by 1, 2, 4 or 8.
// (R2) The fast divider field in bits 5:4 divides the 24 MHz clock by 1, 2, 4 or 8.
// (R3) Bits 3:2 pick off, slow/M or fast/N for the output in every state but sleep and power down.
// (R4) Bits 1:0 pick the output source in the same encoding while sleeping.
// (R5) The clock output configuration resets to 8'h29: M=1, N=4, fast/4 awake, slow/1 asleep.
// (R6) The fast oscillator runs only in idle, transmit and receive and stops otherwise.
// (R7) In receive the fast reference is doubled for the digital processing.
// (R8) The slow oscillator always runs while powered and times the real-time clock; its enable here is low until two clocks after resetn_i rises.
// (R9) In sleep and power down the output carries the slow clock or a fraction of it.
// (R10) Outside sleep and power down the output may carry the fast clock or a fraction of it.
// (R11) There are five power modes and the microcontroller selects and changes them.
// (R12) Idle powers down the transmit and receive paths but keeps the fast oscillator on.
// (R13) Sleep switches off everything except the slow real-time clock.
// (R14) Setting global power down enters the power down mode.
// (R15) Restoring the supply produces a power-on reset that initialises the logic.
// (R16) An external fast reference must be 24 MHz, 1:1 duty cycle, within 40 ppm.
// (R17) Select value 3 means off, and source changes never produce runt pulses; sleep or power down entry can cut a fast high phase short.
module ccpm_top
  import ccpm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DIV_SEL_W = 2
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic fast_ref_i,
  input wire logic slow_ref_i,
  output logic fast_osc_enable_o,
  output logic slow_osc_enable_o,
  output logic rx_clock_doubler_o,
  output logic tx_path_enable_o,
  output logic rx_path_enable_o,
  output logic rtc_tick_o,
  output logic [2:0] power_state_o,
  output logic clock_output_pin_o
);

  if (ADDR_W < 8 || DIV_SEL_W != 2)
  begin : g_check
    $error("ccpm_top: ADDR_W must be at least 8 and DIV_SEL_W must be 2");
  end

  localparam logic [1:0] REG_CFG = 2'h0;
  localparam logic [1:0] REG_PWR = 2'h1;
  localparam logic [1:0] REG_STS = 2'h2;
  localparam logic [1:0] REG_NONE = 2'h3;

  // Byte address decode shared by the read and write paths.
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    if (w == `CCPM_OFF_CLK_CFG)
      return REG_CFG;
    else if (w == `CCPM_OFF_PWR_CTRL)
      return REG_PWR;
    else if (w == `CCPM_OFF_STATUS)
      return REG_STS;
    else
      return REG_NONE;
  endfunction

  function automatic ccpm_pstate_t power_state(input ccpm_mode_t m, input logic global_power_down);
    ccpm_pstate_t ps;
    if (global_power_down)
      ps = CCPM_PS_PDOWN; // (R14)
    else
    begin
      unique case (m)
        CCPM_MODE_IDLE: ps = CCPM_PS_IDLE;
        CCPM_MODE_TX: ps = CCPM_PS_TX;
        CCPM_MODE_RX: ps = CCPM_PS_RX;
        CCPM_MODE_SLEEP: ps = CCPM_PS_SLEEP;
      endcase
    end
    return ps;
  endfunction

  logic [1:0] rst_sync_reg;
  logic rst_n;
  ccpm_state_t state_reg;
  ccpm_state_t state_next;

  logic fast_level;
  logic fast_rise;
  logic slow_level;
  logic slow_rise;
  logic fast_div_clk;
  logic slow_div_clk;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic have_aw;
  logic have_w;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_strb0;
  logic sleepish;
  logic [1:0] sel_field;
  ccpm_src_t want_src;
  logic cur_level;
  logic want_level;
  logic [31:0] status_word;

  // Power-on reset: the supply detector drives resetn_i, released here in two stages.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync_reg <= 2'h0; // (R15)
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  ccpm_sync u_fast_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .async_i(fast_ref_i),
    .level_o(fast_level),
    .rise_o(fast_rise)
  );

  ccpm_sync u_slow_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .async_i(slow_ref_i),
    .level_o(slow_level),
    .rise_o(slow_rise)
  );

  // The fast divider is held when the oscillator is stopped so that no stale edges leak out.
  ccpm_divider #(
    .SEL_W(DIV_SEL_W)
  ) u_fast_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .enable_i(state_reg.fast_en),
    .level_i(fast_level),
    .rise_i(fast_rise),
    .ratio_i(state_reg.clk_cfg[`CCPM_FAST_DIV_LSB +: 2]), // (R2)
    .clock_o(fast_div_clk)
  );

  ccpm_divider #(
    .SEL_W(DIV_SEL_W)
  ) u_slow_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .enable_i(1'b1), // (R8)
    .level_i(slow_level),
    .rise_i(slow_rise),
    .ratio_i(state_reg.clk_cfg[`CCPM_SLOW_DIV_LSB +: 2]), // (R1)
    .clock_o(slow_div_clk)
  );

  assign aw_fire = s_axi_awvalid_i & s_axi_awready_o;
  assign w_fire = s_axi_wvalid_i & s_axi_wready_o;
  assign ar_fire = s_axi_arvalid_i & s_axi_arready_o;

  always_comb
  begin
    state_next = state_reg;

    // Write address and data are taken independently and joined once both are present.
    have_aw = state_reg.aw_held | aw_fire;
    have_w = state_reg.w_held | w_fire;
    wr_addr = state_reg.aw_held ? state_reg.aw_addr : s_axi_awaddr_i[7:0];
    wr_data = state_reg.w_held ? state_reg.w_data : s_axi_wdata_i[7:0];
    wr_strb0 = state_reg.w_held ? state_reg.w_strb0 : s_axi_wstrb_i[0];
    if (aw_fire)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr_i[7:0];
    end
    if (w_fire)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata_i[7:0];
      state_next.w_strb0 = s_axi_wstrb_i[0];
    end
    if (state_reg.bvalid && s_axi_bready_i)
      state_next.bvalid = 1'b0;
    if (have_aw && have_w && !state_reg.bvalid)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = `CCPM_RESP_OKAY;
      unique case (reg_sel(wr_addr))
        REG_CFG:
        begin
          if (wr_strb0)
            state_next.clk_cfg = wr_data;
        end
        REG_PWR:
        begin
          // The microcontroller commands every mode change through this register.
          if (wr_strb0)
          begin
            state_next.mode = ccpm_mode_t'(wr_data[`CCPM_MODE_LSB +: 2]); // (R11)
            state_next.global_power_down = wr_data[`CCPM_GPD_BIT]; // (R14)
          end
        end
        REG_STS:
          state_next.bresp = `CCPM_RESP_OKAY;
        REG_NONE:
          state_next.bresp = `CCPM_RESP_DECERR;
      endcase
    end

    // Power state and the analogue enables are registered from the next mode, in the same cycle as the mode.
    state_next.pstate = power_state(state_next.mode, state_next.global_power_down); // (R11)
    state_next.fast_en = (state_next.pstate == CCPM_PS_IDLE) ||
                         (state_next.pstate == CCPM_PS_TX) ||
                         (state_next.pstate == CCPM_PS_RX); // (R6) (R12) (R13)
    state_next.doubler = (state_next.pstate == CCPM_PS_RX); // (R7)
    state_next.tx_en = (state_next.pstate == CCPM_PS_TX); // (R12) (R13)
    state_next.rx_en = (state_next.pstate == CCPM_PS_RX); // (R12) (R13)

    // Source selection for the clock output pin.
    sleepish = (state_reg.pstate == CCPM_PS_SLEEP) || (state_reg.pstate == CCPM_PS_PDOWN);
    if (sleepish)
      sel_field = state_reg.clk_cfg[`CCPM_SLP_SEL_LSB +: 2]; // (R4)
    else
      sel_field = state_reg.clk_cfg[`CCPM_ACT_SEL_LSB +: 2]; // (R3) (R10)
    want_src = ccpm_decode_src(sel_field); // (R17)
    // The fast oscillator is stopped while asleep, so a fast choice falls back to slow/M.
    if (sleepish && want_src == CCPM_SRC_FAST)
      want_src = CCPM_SRC_SLOW; // (R9)

    unique case (state_reg.cur_src)
      CCPM_SRC_SLOW: cur_level = slow_div_clk;
      CCPM_SRC_FAST: cur_level = fast_div_clk;
      default: cur_level = 1'b0;
    endcase
    unique case (want_src)
      CCPM_SRC_SLOW: want_level = slow_div_clk;
      CCPM_SRC_FAST: want_level = fast_div_clk;
      default: want_level = 1'b0;
    endcase

    // A change waits for the old source to go low, then for the new one to be low,
    // so high phases on the pin are whole unless sleep or power down entry clears the fast divider mid-phase.
    unique case (state_reg.sw)
      CCPM_SW_RUN:
      begin
        state_next.pin = cur_level;
        if (want_src != state_reg.cur_src)
        begin
          state_next.sw = CCPM_SW_DRAIN;
          state_next.pin = cur_level & state_reg.pin; // (R17)
        end
      end
      CCPM_SW_DRAIN:
      begin
        state_next.pin = cur_level & state_reg.pin;
        if (!state_next.pin)
        begin
          state_next.cur_src = want_src;
          state_next.sw = CCPM_SW_ARM; // (R17)
        end
      end
      CCPM_SW_ARM:
      begin
        state_next.pin = 1'b0;
        if (state_reg.cur_src != want_src)
          state_next.cur_src = want_src;
        else if (!cur_level)
          state_next.sw = CCPM_SW_RUN; // (R17)
      end
    endcase

    // Read path.
    status_word = '0;
    status_word[`CCPM_ST_STATE_LSB +: 3] = state_reg.pstate;
    status_word[`CCPM_ST_FAST_BIT] = state_reg.fast_en;
    status_word[`CCPM_ST_DOUBLER_BIT] = state_reg.doubler;
    status_word[`CCPM_ST_PIN_BIT] = state_reg.pin;
    status_word[`CCPM_ST_SRC_LSB +: 2] = state_reg.cur_src;
    if (state_reg.rvalid && s_axi_rready_i)
      state_next.rvalid = 1'b0;
    if (ar_fire)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = '0;
      state_next.rresp = `CCPM_RESP_OKAY;
      unique case (reg_sel(s_axi_araddr_i[7:0]))
        REG_CFG: state_next.rdata[7:0] = state_reg.clk_cfg;
        REG_PWR:
        begin
          state_next.rdata[`CCPM_MODE_LSB +: 2] = state_reg.mode;
          state_next.rdata[`CCPM_GPD_BIT] = state_reg.global_power_down;
        end
        REG_STS: state_next.rdata = status_word;
        REG_NONE: state_next.rresp = `CCPM_RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.clk_cfg <= `CCPM_CLK_CFG_RESET; // (R5)
      state_reg.mode <= ccpm_mode_t'(2'(`CCPM_PWR_CTRL_RESET >> `CCPM_MODE_LSB));
      state_reg.pstate <= CCPM_PS_IDLE;
      state_reg.fast_en <= 1'b1;
      state_reg.sw <= CCPM_SW_ARM;
      state_reg.cur_src <= CCPM_SRC_OFF;
    end
    else
      state_reg <= state_next;
  end

  assign s_axi_awready_o = ~state_reg.aw_held & ~state_reg.bvalid;
  assign s_axi_wready_o = ~state_reg.w_held & ~state_reg.bvalid;
  assign s_axi_bvalid_o = state_reg.bvalid;
  assign s_axi_bresp_o = state_reg.bresp;
  assign s_axi_arready_o = ~state_reg.rvalid;
  assign s_axi_rvalid_o = state_reg.rvalid;
  assign s_axi_rdata_o = state_reg.rdata;
  assign s_axi_rresp_o = state_reg.rresp;

  assign fast_osc_enable_o = state_reg.fast_en; // (R6)
  assign slow_osc_enable_o = rst_sync_reg[1]; // (R8)
  assign rx_clock_doubler_o = state_reg.doubler; // (R7)
  assign tx_path_enable_o = state_reg.tx_en;
  assign rx_path_enable_o = state_reg.rx_en;
  assign rtc_tick_o = slow_rise; // (R8)
  assign power_state_o = state_reg.pstate;
  assign clock_output_pin_o = state_reg.pin; // (R9) (R10)

endmodule

// File: verif/ccpm_ref_model.sv
// Crystal oscillator stand-ins that feed the fast and slow reference inputs.
`timescale 1ns/1ns
module ccpm_ref_model
#(
  parameter int FAST_HALF_NS = 21,
  parameter int SLOW_HALF_NS = 15259
)
(
  input wire logic fast_enable_i,
  output logic fast_ref_o,
  output logic slow_ref_o
);
  // A stopped crystal leaves its pin low, so the block must not rely on a last edge.
  initial
  begin
    fast_ref_o = 1'b0;
    forever
    begin
      #FAST_HALF_NS;
      fast_ref_o = (fast_enable_i === 1'b1) ? ~fast_ref_o : 1'b0;
    end
  end
  initial
  begin
    slow_ref_o = 1'b0;
    forever #SLOW_HALF_NS slow_ref_o = ~slow_ref_o;
  end
endmodule

// File: verif/ccpm_checker.sv
// Concurrent checks on the power mode and oscillator outputs of the clock output block.
`timescale 1ns/1ns
module ccpm_checker
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic s_axi_bvalid_o,
  input wire logic fast_osc_enable_o,
  input wire logic slow_osc_enable_o,
  input wire logic rx_clock_doubler_o,
  input wire logic tx_path_enable_o,
  input wire logic rx_path_enable_o,
  input wire logic rtc_tick_o,
  input wire logic [2:0] power_state_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  property p_fast_gate; fast_osc_enable_o == (power_state_o < 3'h3); endproperty
  a_fast_gate: assert property (p_fast_gate)
    else $error("fast oscillator enable disagrees with power state");
  property p_doubler; rx_clock_doubler_o == (power_state_o == 3'h2); endproperty
  a_doubler: assert property (p_doubler)
    else $error("doubler disagrees with power state");
  property p_paths;
    tx_path_enable_o == (power_state_o == 3'h1) && rx_path_enable_o == (power_state_o == 3'h2);
  endproperty
  a_paths: assert property (p_paths)
    else $error("path enables disagree with power state");
  property p_sleep_off;
    power_state_o >= 3'h3 |-> !(tx_path_enable_o || rx_path_enable_o || rx_clock_doubler_o);
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("circuit left running in sleep or power down");
  property p_slow_run; resetn_i [*3] |-> slow_osc_enable_o; endproperty
  a_slow_run: assert property (p_slow_run)
    else $error("slow oscillator not running while powered");
  property p_tick; rtc_tick_o |=> !rtc_tick_o [*8]; endproperty
  a_tick: assert property (p_tick)
    else $error("real-time clock tick is not a single pulse");
  property p_state_code; power_state_o <= 3'h4; endproperty
  a_state_code: assert property (p_state_code)
    else $error("power state outside the five modes");
  property p_state_cause; !$stable(power_state_o) |-> $rose(s_axi_bvalid_o); endproperty
  a_state_cause: assert property (p_state_cause)
    else $error("power state changed without a register write");
  c_pdown: cover property (power_state_o == 3'h4);
  c_sleep_tick: cover property (rtc_tick_o && power_state_o == 3'h3);
  c_rx: cover property ($rose(rx_clock_doubler_o));
endmodule

bind ccpm_top ccpm_checker chk_u (.clk_i, .resetn_i, .s_axi_bvalid_o, .fast_osc_enable_o,
  .slow_osc_enable_o, .rx_clock_doubler_o, .tx_path_enable_o, .rx_path_enable_o, .rtc_tick_o,
  .power_state_o);

// File: verif/tb.sv
// Self-checking bench of the clock output and power mode block.
`timescale 1ns/1ns
`include "ccpm_map.svh"
module tb;
  // Shortened slow half period keeps divide-by-8 runs brief.
  localparam int FH = 21;
  localparam int SH = 200;
  logic clk = 1'b0, resetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic arv = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cfg;
  logic [31:0] wdata = 32'h0000_0000, rnd = 32'hc1b8_c54e, rdat;
  logic [3:0] wstrb = 4'hf;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, fref, sref, fen, sen, dbl, txen, rxen, tick, pin;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata;
  logic [2:0] pst;
  int err_count = 0, checks_done = 0, cyc = 0, n;

  ccpm_top dut_u (.clk_i(clk), .resetn_i(resetn), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .fast_ref_i(fref), .slow_ref_i(sref), .fast_osc_enable_o(fen), .slow_osc_enable_o(sen),
    .rx_clock_doubler_o(dbl), .tx_path_enable_o(txen), .rx_path_enable_o(rxen),
    .rtc_tick_o(tick), .power_state_o(pst), .clock_output_pin_o(pin));
  ccpm_ref_model #(.FAST_HALF_NS(FH), .SLOW_HALF_NS(SH)) ref_u (.fast_enable_i(fen),
    .fast_ref_o(fref), .slow_ref_o(sref));

  initial forever #5 clk = ~clk;

  task automatic test_done();
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      err_count++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Sleep serves a fast select as slow/M because the fast oscillator is stopped.
  function automatic int exp_ns(input logic [1:0] sel, m, nd, input bit slp);
    if (sel == 2'h1 || (slp && sel == 2'h2)) return 2 * SH * (1 << m);
    if (sel == 2'h2) return 2 * FH * (1 << nd);
    return 0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Handshakes are judged at the falling edge so the rising edge carries no race.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic a_t, w_t, b_t;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t)
    begin
      @(negedge clk);
      a_t = awv & awrdy;
      w_t = wv & wrdy;
      b_t = (bvalid === 1'b1);
      if (b_t) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk);
      if (a_t) awv <= 1'b0;
      if (w_t) wv <= 1'b0;
    end
    // One idle edge keeps a following call from raising bready in this same step.
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    logic a_t, v_t;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    v_t = 1'b0;
    while (!v_t)
    begin
      @(negedge clk);
      a_t = arv & arrdy;
      v_t = (rvalid === 1'b1);
      rdat = rdata;
      rr = rresp;
      @(posedge clk);
      if (a_t) arv <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a);
    chk("rdata", e, rdat);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask

  // The first 400 cycles let the glitch-free switch drain the old source.
  task automatic meas(input int e);
    time t0;
    int hi;
    repeat (400) @(posedge clk);
    hi = 0;
    if (e == 0)
    begin
      repeat (400)
      begin
        @(posedge clk);
        if (pin !== 1'b0) hi++;
      end
      chk("pin_off", 32'h0, hi);
    end
    else
    begin
      @(posedge pin);
      t0 = $time;
      repeat (4) @(posedge pin);
      hi = $time - t0 - 4 * e;
      chk("pin_period_ok", 32'h1, {31'h0, (hi <= 20 && hi >= -20)});
    end
  endtask

  initial
  begin
    do_reset();
    rc(`CCPM_OFF_CLK_CFG, 32'h0000_0029, 2'h0);
    rc(`CCPM_OFF_PWR_CTRL, 32'h0000_0000, 2'h0);
    chk("fast_osc_enable", 32'h1, {31'h0, fen});
    chk("slow_osc_enable", 32'h1, {31'h0, sen});
    meas(exp_ns(2'h2, 2'h0, 2'h2, 1'b0));
    wr(8'h0c, rnd, 2'h3);
    rc(8'h10, 32'h0000_0000, 2'h3);
    wstrb <= 4'h0;
    wr(`CCPM_OFF_CLK_CFG, 32'h0000_00ff, 2'h0);
    wstrb <= 4'hf;
    rc(`CCPM_OFF_CLK_CFG, 32'h0000_0029, 2'h0);
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      cfg = {i[1:0], i[1:0] ^ rnd[5:4], i[3:2], rnd[1:0]};
      wr(`CCPM_OFF_CLK_CFG, {rnd[31:8], cfg}, 2'h0);
      rc(`CCPM_OFF_CLK_CFG, {24'h0, cfg}, 2'h0);
      meas(exp_ns(cfg[3:2], cfg[7:6], cfg[5:4], 1'b0));
    end
    for (int p = 0; p < 5; p++)
    begin
      rnd = lfsr(rnd);
      cfg = {rnd[7:4], 2'h2, rnd[1:0]};
      wr(`CCPM_OFF_CLK_CFG, {24'h0, cfg}, 2'h0);
      wr(`CCPM_OFF_PWR_CTRL, (p == 4) ? {27'h0, 1'b1, 2'h0, rnd[9:8]} : p, 2'h0);
      chk("power_state", p, {29'h0, pst});
      chk("fast_osc_enable", p < 3, {31'h0, fen});
      chk("doubler", p == 2, {31'h0, dbl});
      chk("tx_path", p == 1, {31'h0, txen});
      chk("rx_path", p == 2, {31'h0, rxen});
      wr(`CCPM_OFF_STATUS, 32'h0000_00ff, 2'h0);
      rd(`CCPM_OFF_STATUS);
      chk("status_state", p, {29'h0, rdat[2:0]});
      meas(exp_ns(p < 3 ? 2'h2 : cfg[1:0], cfg[7:6], cfg[5:4], p >= 3));
      n = 0;
      repeat (1000)
      begin
        @(posedge clk);
        if (tick === 1'b1) n++;
      end
      chk("rtc_ticks_ok", 32'h1, {31'h0, (n >= 24 && n <= 26)});
    end
    do_reset();
    rc(`CCPM_OFF_CLK_CFG, 32'h0000_0029, 2'h0);
    rc(`CCPM_OFF_PWR_CTRL, 32'h0000_0000, 2'h0);
    chk("power_state", 32'h0, {29'h0, pst});
    test_done();
  end
endmodule
